// ---- stl_defines.svh ----
`ifndef STL_DEFINES_SVH
`define STL_DEFINES_SVH

// Widths of the datapath
`define STL_LIM_W 12
`define STL_DATA_W 16
`define STL_ADDR_W 4
`define STL_VOLT_W 10
`define STL_CODE_W 8
`define STL_LOSS_W 20
`define STL_PIN_W 9

// Register offsets of the plain register port
`define STL_REG_FWD 4'h0
`define STL_REG_REV 4'h1
`define STL_REG_INT2 4'h2
`define STL_REG_SCA 4'h3
`define STL_REG_SCB 4'h4
`define STL_REG_STAT 4'h5

// Reset values of the limit and scaling registers
`define STL_FWD_RST 12'h03E8
`define STL_REV_RST 12'h03E8
`define STL_INT2_RST 12'h03E8
`define STL_SCA_RST 16'h0001
`define STL_SCB_RST 16'h0001
`define STL_NO_LIMIT 12'h0FFF

// Status word field positions
`define STL_ST_CODE_LSB 0
`define STL_ST_ALARM 8
`define STL_ST_TLC 9
`define STL_ST_HOME 10
`define STL_ST_BASE 11

// Positions in the synchronised pin vector
`define STL_PIN_ILS 0
`define STL_PIN_ELS 1
`define STL_PIN_SON 2
`define STL_PIN_RES 3
`define STL_PIN_OC 4
`define STL_PIN_OL1 5
`define STL_PIN_OL2 6
`define STL_PIN_REGEN 7
`define STL_PIN_LOSS 8

// Alarm codes
`define STL_CODE_NONE 8'h00
`define STL_CODE_UV 8'h10
`define STL_CODE_REGEN 8'h30
`define STL_CODE_OC 8'h32
`define STL_CODE_OL1 8'h50
`define STL_CODE_OL2 8'h51

// Bus undervoltage thresholds in volts, per supply variant
`define STL_THR_STD 10'h00C8
`define STL_THR_LOW 10'h009E
`define STL_THR_HIGH 10'h017C
`define STL_VAR_STD 0
`define STL_VAR_LOW 1
`define STL_VAR_HIGH 2

// Control supply loss time and its cycle count
`define STL_CLK_HZ 10000000
`define STL_LOSS_MS 60
`define STL_LOSS_CYC ((`STL_LOSS_MS * `STL_CLK_HZ + 999) / 1000)

`endif

// ---- stl_pkg.sv ----
package stl_pkg;
  // Alarm latch state, Gray coded
  typedef enum logic [1:0] {
    STL_RUN = 2'h0,
    STL_ALARM = 2'h1
  } stl_alarm_st_type;
endpackage

// ---- stl_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stl_defines.svh"

// Three-stage pin synchroniser; a change is accepted once stages two
// and three agree, so a single metastable sample never gets through.
module stl_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [W-1:0] d_i, // Raw pin levels
  output logic [W-1:0] q_o // Accepted levels
);
  logic [W-1:0] s1_reg; // First stage, read only by s2
  logic [W-1:0] s2_reg; // Second stage
  logic [W-1:0] s3_reg; // Third stage
  logic [W-1:0] q_reg; // Accepted value
  logic [W-1:0] q_next;

  // Accept each bit where the last two stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
    end
  end

  // Shift chain and accepted value
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule
`default_nettype wire

// ---- stl_pulse_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stl_defines.svh"

// Encoder output pulse scaler: each feedback pulse adds scale A to an
// accumulator; each time it reaches scale B one output edge is made.
// The output period is therefore the feedback period times twice B over A.
module stl_pulse_gen (
  input wire logic mclk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [`STL_DATA_W-1:0] scale_a_i, // Numerator
  input wire logic [`STL_DATA_W-1:0] scale_b_i, // Denominator
  input wire logic fb_pulse_i, // One feedback pulse, one cycle
  output logic pulse_o // Scaled output pulse train
);
  logic [`STL_DATA_W:0] acc_reg; // Fraction accumulator
  logic [`STL_DATA_W:0] acc_next;
  logic pulse_reg; // Output level
  logic pulse_next;
  logic [`STL_DATA_W:0] sum; // Accumulator plus numerator

  // Next accumulator and toggle; a zero denominator stops the output
  always_comb begin
    sum = acc_reg + {1'b0, scale_a_i};
    acc_next = acc_reg;
    pulse_next = pulse_reg;
    if (fb_pulse_i && scale_b_i != '0) begin
      if (sum >= {1'b0, scale_b_i}) begin
        acc_next = sum - {1'b0, scale_b_i};
        pulse_next = !pulse_reg;
      end else begin
        acc_next = sum;
      end
    end
  end

  // Register state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      acc_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse_o = pulse_reg;
endmodule
`default_nettype wire

// ---- stl_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stl_defines.svh"

module stl_top #(
  parameter int LOSS_CYCLES = `STL_LOSS_CYC, // Supply loss time in cycles
  parameter int VARIANT = `STL_VAR_STD, // Supply voltage variant
  parameter bit INCREMENTAL = 1'b1 // Incremental encoder system
) (
  input wire logic mclk_i, // System clock, 10 MHz
  input wire logic rst_n_i, // Synchronous reset, also power cycle
  input wire logic [`STL_ADDR_W-1:0] addr_i, // Register address
  input wire logic [`STL_DATA_W-1:0] wdata_i, // Register write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [`STL_DATA_W-1:0] rdata_o, // Read data, next cycle
  input wire logic internal_limit_select_i, // Pin, internal select
  input wire logic external_limit_select_i, // Pin, external select
  input wire logic servo_on_input_i, // Pin, servo on
  input wire logic alarm_reset_input_i, // Pin, alarm reset
  input wire logic overcurrent_i, // Pin, overcurrent detector
  input wire logic overload1_i, // Pin, overload level one
  input wire logic overload2_i, // Pin, overload level two
  input wire logic regen_fault_i, // Pin, regenerative fault
  input wire logic ctrl_supply_lost_i, // Pin, control supply missing
  input wire logic [`STL_LIM_W-1:0] analog_torque_limit_i, // ADC sample
  input wire logic [`STL_LIM_W-1:0] motor_torque_i, // Torque magnitude
  input wire logic ccw_drive_i, // High while driving CCW
  input wire logic [`STL_VOLT_W-1:0] bus_voltage_i, // Bus volts
  input wire logic home_done_i, // Home return complete, pulse
  input wire logic fb_pulse_i, // Feedback pulse, one cycle
  output logic base_drive_en_o, // Power stage enable
  output logic torque_limited_flag_o, // Torque at limit
  output logic [`STL_LIM_W-1:0] active_limit_o, // Limit in force
  output logic alarm_o, // Alarm latched
  output logic [`STL_CODE_W-1:0] alarm_code_o, // Latched alarm code
  output logic home_valid_o, // Home position valid
  output logic enc_pulse_o // Scaled encoder pulse output
);
  // Synchronised pins
  logic [`STL_PIN_W-1:0] pins_raw; // Pin levels as they arrive
  logic [`STL_PIN_W-1:0] pins_q; // Accepted pin levels

  // Software registers
  logic [`STL_LIM_W-1:0] fwd_reg, fwd_next; // Forward limit param
  logic [`STL_LIM_W-1:0] rev_reg, rev_next; // Reverse limit param
  logic [`STL_LIM_W-1:0] int2_reg, int2_next; // Internal limit two
  logic [`STL_DATA_W-1:0] sca_reg, sca_next; // Pulse scale A
  logic [`STL_DATA_W-1:0] scb_reg, scb_next; // Pulse scale B
  logic [`STL_DATA_W-1:0] rdata_reg, rdata_next; // Read data

  // Alarm state
  stl_pkg::stl_alarm_st_type st_reg, st_next; // Alarm latch
  logic [`STL_CODE_W-1:0] code_reg, code_next; // Latched code
  logic [`STL_LOSS_W-1:0] loss_reg, loss_next; // Supply loss timer
  logic res_prev_reg, res_prev_next; // Last reset pin level
  logic base_reg, base_next; // Base drive enable
  logic home_reg, home_next; // Home valid
  logic alarm_reg, alarm_next; // Alarm flag driving the pin
  logic [`STL_CODE_W-1:0] cause; // Cause present now, or none
  logic res_rise; // Alarm reset off-to-on
  logic uv_loss; // Supply loss has lasted long enough
  logic uv_bus; // Bus at or below threshold

  // Torque limiting
  logic [`STL_LIM_W-1:0] cand; // Limit chosen by the selects
  logic [`STL_LIM_W-1:0] lim_fwd; // CCW-driving limit
  logic [`STL_LIM_W-1:0] lim_rev; // CW-driving limit
  logic [`STL_LIM_W-1:0] act_next, act_reg; // Limit in force
  logic tlc_next, tlc_reg; // Torque limited flag
  logic [1:0] sel; // {internal, external} select

  // Lesser of two limits
  function automatic logic [`STL_LIM_W-1:0] lmin(
    input logic [`STL_LIM_W-1:0] a,
    input logic [`STL_LIM_W-1:0] b
  );
    lmin = (a < b) ? a : b;
  endfunction

  // Bus threshold for the configured supply variant
  function automatic logic [`STL_VOLT_W-1:0] bus_thr(input int v);
    case (v)
      `STL_VAR_LOW: bus_thr = `STL_THR_LOW;
      `STL_VAR_HIGH: bus_thr = `STL_THR_HIGH;
      default: bus_thr = `STL_THR_STD;
    endcase
  endfunction

  // All host pins cross through one synchroniser
  assign pins_raw = {ctrl_supply_lost_i, regen_fault_i, overload2_i,
    overload1_i, overcurrent_i, alarm_reset_input_i, servo_on_input_i,
    external_limit_select_i, internal_limit_select_i};

  stl_sync #(.W(`STL_PIN_W)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(pins_raw),
    .q_o(pins_q)
  );

  // Register port: writes update, reads answer one cycle later
  always_comb begin
    fwd_next = fwd_reg;
    rev_next = rev_reg;
    int2_next = int2_reg;
    sca_next = sca_reg;
    scb_next = scb_reg;
    rdata_next = '0;
    if (wr_i) begin
      case (addr_i)
        `STL_REG_FWD: fwd_next = wdata_i[`STL_LIM_W-1:0];
        `STL_REG_REV: rev_next = wdata_i[`STL_LIM_W-1:0];
        `STL_REG_INT2: int2_next = wdata_i[`STL_LIM_W-1:0];
        `STL_REG_SCA: sca_next = wdata_i;
        `STL_REG_SCB: scb_next = wdata_i;
        default: ; // Status and unmapped: write ignored
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        `STL_REG_FWD: rdata_next = {4'h0, fwd_reg};
        `STL_REG_REV: rdata_next = {4'h0, rev_reg};
        `STL_REG_INT2: rdata_next = {4'h0, int2_reg};
        `STL_REG_SCA: rdata_next = sca_reg;
        `STL_REG_SCB: rdata_next = scb_reg;
        `STL_REG_STAT: begin
          rdata_next[`STL_ST_CODE_LSB +: `STL_CODE_W] = code_reg;
          rdata_next[`STL_ST_ALARM] = (st_reg == stl_pkg::STL_ALARM);
          rdata_next[`STL_ST_TLC] = tlc_reg;
          rdata_next[`STL_ST_HOME] = home_reg;
          rdata_next[`STL_ST_BASE] = base_reg;
        end
        default: rdata_next = '0; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fwd_reg <= `STL_FWD_RST;
      rev_reg <= `STL_REV_RST;
      int2_reg <= `STL_INT2_RST;
      sca_reg <= `STL_SCA_RST;
      scb_reg <= `STL_SCB_RST;
      rdata_reg <= '0;
    end else begin
      fwd_reg <= fwd_next;
      rev_reg <= rev_next;
      int2_reg <= int2_next;
      sca_reg <= sca_next;
      scb_reg <= scb_next;
      rdata_reg <= rdata_next;
    end
  end

  // Torque limit selection, recomputed every cycle from fresh samples
  always_comb begin
    sel = {pins_q[`STL_PIN_ILS], pins_q[`STL_PIN_ELS]};
    unique case (sel)
      2'b00: cand = `STL_NO_LIMIT;
      2'b01: cand = analog_torque_limit_i;
      2'b10: cand = int2_reg;
      2'b11: cand = lmin(analog_torque_limit_i, int2_reg);
    endcase
    // Parameter limits bound every selection, per direction
    lim_fwd = lmin(cand, fwd_reg);
    lim_rev = lmin(cand, rev_reg);
    act_next = ccw_drive_i ? lim_fwd : lim_rev;
    tlc_next = (motor_torque_i >= act_next);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      act_reg <= `STL_FWD_RST;
      tlc_reg <= 1'b0;
    end else begin
      act_reg <= act_next;
      tlc_reg <= tlc_next;
    end
  end

  // Alarm detection and latch; reset flop doubles as power cycle
  always_comb begin
    uv_loss = (loss_reg == LOSS_CYCLES[`STL_LOSS_W-1:0]);
    uv_bus = (bus_voltage_i <= bus_thr(VARIANT));
    loss_next = loss_reg;
    if (!pins_q[`STL_PIN_LOSS]) begin
      loss_next = '0;
    end else if (!uv_loss) begin
      loss_next = loss_reg + 1'b1;
    end
    // Fixed priority picks one code when causes coincide
    if (pins_q[`STL_PIN_OC]) begin
      cause = `STL_CODE_OC;
    end else if (pins_q[`STL_PIN_OL2]) begin
      cause = `STL_CODE_OL2;
    end else if (pins_q[`STL_PIN_OL1]) begin
      cause = `STL_CODE_OL1;
    end else if (pins_q[`STL_PIN_REGEN]) begin
      cause = `STL_CODE_REGEN;
    end else if (uv_loss || uv_bus) begin
      cause = `STL_CODE_UV;
    end else begin
      cause = `STL_CODE_NONE;
    end
    res_prev_next = pins_q[`STL_PIN_RES];
    res_rise = pins_q[`STL_PIN_RES] && !res_prev_reg;
    st_next = st_reg;
    code_next = code_reg;
    unique case (st_reg)
      stl_pkg::STL_RUN: begin
        if (cause != `STL_CODE_NONE) begin
          st_next = stl_pkg::STL_ALARM;
          code_next = cause;
        end
      end
      stl_pkg::STL_ALARM: begin
        // Regenerative fault leaves only through a power cycle
        if (res_rise && cause == `STL_CODE_NONE &&
            code_reg != `STL_CODE_REGEN) begin
          st_next = stl_pkg::STL_RUN;
          code_next = `STL_CODE_NONE;
        end
      end
    endcase
    // Base drive drops in the same cycle the alarm is taken
    base_next = pins_q[`STL_PIN_SON] &&
      (st_next == stl_pkg::STL_RUN);
    alarm_next = (st_next == stl_pkg::STL_ALARM);
    home_next = home_reg;
    if (!INCREMENTAL) begin
      home_next = 1'b1;
    end else if (st_next == stl_pkg::STL_ALARM) begin
      home_next = 1'b0;
    end else if (home_done_i) begin
      home_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_reg <= stl_pkg::STL_RUN;
      code_reg <= `STL_CODE_NONE;
      loss_reg <= '0;
      res_prev_reg <= 1'b0;
      base_reg <= 1'b0;
      home_reg <= 1'b0;
      alarm_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      code_reg <= code_next;
      loss_reg <= loss_next;
      res_prev_reg <= res_prev_next;
      base_reg <= base_next;
      home_reg <= home_next;
      alarm_reg <= alarm_next;
    end
  end

  // Encoder output pulse scaling
  stl_pulse_gen u_pulse (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .scale_a_i(sca_reg),
    .scale_b_i(scb_reg),
    .fb_pulse_i(fb_pulse_i),
    .pulse_o(enc_pulse_o)
  );

  assign rdata_o = rdata_reg;
  assign base_drive_en_o = base_reg;
  assign torque_limited_flag_o = tlc_reg;
  assign active_limit_o = act_reg;
  assign alarm_o = alarm_reg;
  assign alarm_code_o = code_reg;
  assign home_valid_o = home_reg;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  base_cut_a: assert property (
    cause != `STL_CODE_NONE |=> !base_drive_en_o && alarm_o)
    else $error("base drive not cut on alarm");
  alarm_hold_a: assert property (
    alarm_o && cause != `STL_CODE_NONE |=> alarm_o && $stable(alarm_code_o))
    else $error("alarm left while cause present");
  reset_clear_a: assert property (
    alarm_o && res_rise && cause == `STL_CODE_NONE &&
    alarm_code_o != `STL_CODE_REGEN |=> !alarm_o)
    else $error("reset edge did not clear alarm");
  param_bound_a: assert property (
    ##1 active_limit_o <= $past(ccw_drive_i ? fwd_reg : rev_reg))
    else $error("limit above parameter");
  sel_none_a: assert property (
    sel == 2'b00 |=> active_limit_o == $past(ccw_drive_i ? fwd_reg : rev_reg))
    else $error("parameter limit not used");
  int_only_a: assert property (
    sel == 2'b10 && int2_reg <= fwd_reg && int2_reg <= rev_reg
    |=> active_limit_o == $past(int2_reg))
    else $error("internal limit two not used");
  tlc_flag_a: assert property (
    motor_torque_i >= act_next |=> torque_limited_flag_o)
    else $error("torque limited flag missing");
  loss_uv_a: assert property (
    !alarm_o && uv_loss && !uv_bus && pins_q[`STL_PIN_REGEN:`STL_PIN_OC] == '0
    |=> alarm_o && alarm_code_o == `STL_CODE_UV)
    else $error("supply loss not raised");
  bus_uv_a: assert property (
    !alarm_o && uv_bus && pins_q[`STL_PIN_REGEN:`STL_PIN_OC] == '0
    |=> alarm_o && alarm_code_o == `STL_CODE_UV)
    else $error("bus undervoltage not raised");
  home_lost_a: assert property (
    INCREMENTAL && cause != `STL_CODE_NONE |=> !home_valid_o)
    else $error("home kept across alarm");
  alarm_entry_c: cover property (!alarm_o ##1 alarm_o);
  alarm_clear_c: cover property (alarm_o ##1 !alarm_o);
  tlc_rise_c: cover property (!torque_limited_flag_o ##1 torque_limited_flag_o);
endmodule
`default_nettype wire

// ---- stl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host controller at the discrete inputs of the amplifier.
// It drops servo-on on any alarm and pulses the alarm reset pin on request.
module stl_host_model (
  input wire logic mclk_i, // System clock
  input wire logic alarm_i, // Alarm state seen from the amplifier
  input wire logic reset_req_i, // One-cycle request for a reset pulse
  output logic servo_on_o, // Servo-on pin
  output logic alarm_reset_o // Alarm reset pin
);
  int hold_cnt; // Cycles left of the reset pulse

  initial begin
    servo_on_o = 1'b1;
    alarm_reset_o = 1'b0;
    hold_cnt = 0;
  end

  // Pulse is six cycles so that it outlasts the pin synchroniser
  always @(posedge mclk_i) begin
    if (alarm_i === 1'b1) begin
      servo_on_o <= 1'b0;
    end else if (hold_cnt == 0) begin
      servo_on_o <= 1'b1;
    end
    if (reset_req_i && hold_cnt == 0 && !alarm_reset_o) begin
      hold_cnt <= 6;
      alarm_reset_o <= 1'b1;
    end else if (hold_cnt > 1) begin
      hold_cnt <= hold_cnt - 1;
    end else begin
      hold_cnt <= 0;
      alarm_reset_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- servo_torque_limit_and_alarm_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "stl_defines.svh"

// Self-checking bench: random torque limit sweeps and alarm sequences
module servo_torque_limit_and_alarm_test;
  logic clk = 1'b0; // 10 MHz system clock
  logic rst_n = 1'b0; // Synchronous reset, also power cycle
  logic [3:0] addr = 4'h0; // Register address
  logic [15:0] wdata = 16'h0000; // Register write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [15:0] rdata; // Read data
  logic ils = 1'b0; // Internal select pin
  logic els = 1'b0; // External select pin
  logic [3:0] cause = 4'h0; // OC, OL1, OL2, regen pins
  logic loss = 1'b0; // Control supply missing pin
  logic [11:0] atl = 12'h0fff; // Analog limit sample
  logic [11:0] torque = 12'h000; // Torque magnitude
  logic ccw = 1'b0; // Driving direction
  logic [9:0] bus = 10'h200; // Bus volts, healthy
  logic home_done = 1'b0; // Home return pulse
  logic fb = 1'b0; // Feedback pulse
  logic reset_req = 1'b0; // Ask host for a reset pulse
  logic servo_on_input, ares, base, torque_limited_flag, alarm, home, enc, enc_q;
  logic [11:0] lim; // Limit in force
  logic [7:0] code; // Alarm code
  logic [15:0] rv; // Read value
  logic [31:0] seed = 32'h0000_fe2d; // Fixed seed keeps runs repeatable
  logic [11:0] f, r, t2, el; // Drawn limits and expected limit
  int n_mismatch = 0;
  int total_checks = 0;
  int n_tog = 0; // Output pulse edges seen
  logic [7:0] codes [4] = '{8'h32, 8'h50, 8'h51, 8'h30}; // Per cause pin

  always #50 clk = ~clk;

  stl_top #(.LOSS_CYCLES(20), .VARIANT(`STL_VAR_STD), .INCREMENTAL(1'b1)) dut (
    .mclk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .internal_limit_select_i(ils),
    .external_limit_select_i(els), .servo_on_input_i(servo_on_input),
    .alarm_reset_input_i(ares), .overcurrent_i(cause[0]),
    .overload1_i(cause[1]), .overload2_i(cause[2]), .regen_fault_i(cause[3]),
    .ctrl_supply_lost_i(loss), .analog_torque_limit_i(atl),
    .motor_torque_i(torque), .ccw_drive_i(ccw), .bus_voltage_i(bus),
    .home_done_i(home_done), .fb_pulse_i(fb), .base_drive_en_o(base),
    .torque_limited_flag_o(torque_limited_flag), .active_limit_o(lim), .alarm_o(alarm),
    .alarm_code_o(code), .home_valid_o(home), .enc_pulse_o(enc));

  stl_host_model host (.mclk_i(clk), .alarm_i(alarm),
    .reset_req_i(reset_req), .servo_on_o(servo_on_input), .alarm_reset_o(ares));

  // Count every change of the scaled pulse output
  always @(posedge clk) begin
    enc_q <= enc;
    if (enc !== enc_q) n_tog++;
  end

  // Galois shift register for repeatable stimulus
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  // Expected limit: selection first, then bounded by direction parameter
  function automatic logic [11:0] exp_lim(input logic i, input logic e,
      input logic c, input logic [11:0] an, input logic [11:0] fw,
      input logic [11:0] rw, input logic [11:0] tw);
    logic [11:0] cand;
    logic [11:0] par;
    cand = 12'hfff;
    if (e && !i) cand = an;
    if (i && !e) cand = tw;
    if (i && e) cand = (an < tw) ? an : tw;
    par = c ? fw : rw;
    return (cand < par) ? cand : par;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // Bounded wait for the alarm state, then compare it
  task automatic wait_alarm(input logic exp, input int n);
    for (int k = 0; k < n && alarm !== exp; k++) @(negedge clk);
    check({15'h0, alarm}, {15'h0, exp});
  endtask

  // One-cycle pulse: 0 home return, 1 reset request, 2 feedback
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: home_done <= 1'b1;
      1: reset_req <= 1'b1;
      default: fb <= 1'b1;
    endcase
    @(posedge clk);
    home_done <= 1'b0;
    reset_req <= 1'b0;
    fb <= 1'b0;
  endtask

  task automatic power_cycle();
    @(posedge clk);
    rst_n <= 1'b0;
    step(3);
    rst_n <= 1'b1;
    step(6);
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the several hundred cycles the run needs
  initial begin
    step(20000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    step(3);
    rst_n <= 1'b1;
    step(4);
    // Reset values, unmapped reads and the read-only status word
    for (int a = 0; a < 5; a++) begin
      reg_rd(a[3:0], rv);
      check(rv, (a < 3) ? 16'h03e8 : 16'h0001);
    end
    for (int a = 6; a < 16; a++) begin
      reg_rd(a[3:0], rv);
      check(rv, 16'h0000);
    end
    reg_wr(`STL_REG_STAT, 16'hffff);
    reg_rd(`STL_REG_STAT, rv);
    check(rv & 16'h05ff, 16'h0000);
    // Random limit sweep; torque often sits exactly on the limit
    for (int k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      f = seed[11:0];
      seed = lfsr(seed);
      r = seed[11:0];
      seed = lfsr(seed);
      t2 = seed[11:0];
      seed = lfsr(seed);
      el = exp_lim(k[1], k[0], seed[12], seed[11:0], f, r, t2);
      reg_wr(`STL_REG_FWD, {4'h0, f});
      reg_wr(`STL_REG_REV, {4'h0, r});
      reg_wr(`STL_REG_INT2, {4'h0, t2});
      ils <= k[1];
      els <= k[0];
      ccw <= seed[12];
      atl <= seed[11:0];
      torque <= (k % 3 == 0) ? el : (k % 3 == 1) ? el - 12'h001 : seed[27:16];
      step(8);
      check({4'h0, lim}, {4'h0, el});
      check({15'h0, torque_limited_flag}, {15'h0, (torque >= el)});
      reg_rd(`STL_REG_FWD, rv);
      check(rv, {4'h0, f});
    end
    // Each cause pin: latch, refused reset, then clearing
    for (int j = 0; j < 4; j++) begin
      pulse(0);
      step(2);
      check({15'h0, home}, 16'h0001);
      cause[j] <= 1'b1;
      wait_alarm(1'b1, 12);
      check({8'h00, code}, {8'h00, codes[j]});
      check({15'h0, base}, 16'h0000);
      check({15'h0, home}, 16'h0000);
      if (j == 0) begin
        reg_rd(`STL_REG_STAT, rv);
        check(rv & 16'h0dff, 16'h0100 | codes[0]);
      end
      pulse(1);
      step(12);
      check({15'h0, alarm}, 16'h0001);
      cause[j] <= 1'b0;
      step(6);
      pulse(1);
      step(12);
      if (j == 3) begin
        check({15'h0, alarm}, 16'h0001);
        power_cycle();
      end
      check({15'h0, alarm}, 16'h0000);
      check({8'h00, code}, 16'h0000);
      step(8);
      check({15'h0, base}, 16'h0001);
    end
    // Supply loss must last the full count before undervoltage
    loss <= 1'b1;
    step(15);
    check({15'h0, alarm}, 16'h0000);
    wait_alarm(1'b1, 20);
    check({8'h00, code}, {8'h00, `STL_CODE_UV});
    step(1);
    loss <= 1'b0;
    step(6);
    pulse(1);
    step(12);
    check({15'h0, alarm}, 16'h0000);
    // Bus threshold boundary: one volt above passes, at threshold trips
    bus <= `STL_THR_STD + 10'h001;
    step(6);
    check({15'h0, alarm}, 16'h0000);
    bus <= `STL_THR_STD;
    wait_alarm(1'b1, 4);
    check({8'h00, code}, {8'h00, `STL_CODE_UV});
    step(1);
    bus <= 10'h200;
    step(2);
    pulse(1);
    step(12);
    check({15'h0, alarm}, 16'h0000);
    // Output pulse scaling: nine feedback pulses at two over three
    reg_wr(`STL_REG_SCA, 16'h0002);
    reg_wr(`STL_REG_SCB, 16'h0003);
    step(2);
    n_tog = 0;
    for (int p = 0; p < 9; p++) begin
      pulse(2);
      step(3);
    end
    check(n_tog[15:0], 16'h0006);
    finish_test();
  end
endmodule
`default_nettype wire
